// file: common/hrp_pkg.sv
// Shared constants and types for the host RAM pointer and configuration register group.
package hrp_pkg;

    typedef logic [7:0]  hrp_byte_t;
    typedef logic [10:0] hrp_addr_t;
    typedef logic [2:0]  hrp_sel_t;
    typedef logic [4:0]  hrp_target_t;
    typedef logic [11:0] hrp_offset_t;

    localparam hrp_offset_t REG_PTR_HIGH   = 12'h000;
    localparam hrp_offset_t REG_PTR_LOW    = 12'h004;
    localparam hrp_offset_t REG_SEL        = 12'h008;
    localparam hrp_offset_t REG_CONFIG     = 12'h00c;

    localparam int PH_READ_BIT       = 7;
    localparam int PH_STEP_BIT       = 6;
    localparam int PH_UPPER_MSB      = 2;
    localparam int CFG_RESET_BIT     = 7;
    localparam int CFG_CHAIN_BIT     = 6;
    localparam int CFG_LINE_DRIVE_ENABLE_BIT      = 5;
    localparam int CFG_BACKPLANE_BIT = 2;
    localparam int CFG_KEEP_LSB      = 2;
    localparam int SEL_SHARED_MSB    = 1;

    localparam hrp_addr_t PTR_RESET  = 11'h000;
    localparam hrp_addr_t PTR_STEP   = 11'h001;
    localparam hrp_sel_t  SEL_RESET  = 3'h0;
    localparam logic [5:0] CFG_RESET = 6'h00;
    localparam hrp_byte_t RD_ZERO    = 8'h00;

    localparam hrp_sel_t SEL_TENTATIVE_ID = 3'h0;
    localparam hrp_sel_t SEL_NODE_ID      = 3'h1;
    localparam hrp_sel_t SEL_SETUP_1      = 3'h2;
    localparam hrp_sel_t SEL_NEXT_ID      = 3'h3;
    localparam hrp_sel_t SEL_SETUP_2      = 3'h4;

    localparam hrp_target_t TGT_TENTATIVE_ID = 5'h01;
    localparam hrp_target_t TGT_NODE_ID      = 5'h02;
    localparam hrp_target_t TGT_SETUP_1      = 5'h04;
    localparam hrp_target_t TGT_NEXT_ID      = 5'h08;
    localparam hrp_target_t TGT_SETUP_2      = 5'h10;
    localparam hrp_target_t TGT_NONE         = 5'h00;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [3:0]
    {
        HRP_ST_IDLE     = 4'b0001,
        HRP_ST_WRITE    = 4'b0010,
        HRP_ST_RD_FETCH = 4'b0100,
        HRP_ST_RD_GIVE  = 4'b1000
    } hrp_bus_state_e;

endpackage : hrp_pkg

// file: design/hrp_host_regs.sv
// Host register group: RAM pointer, indirect register select and device configuration.
//
// Contract
// - Pointer-high bit 7 chooses read (one) or write (zero) for next access.
// - Pointer-high bit 6 set makes the pointer step after each data access.
// - Pointer-high bits 2-0 give RAM address bits 10 down to 8.
// - Pointer-low bits 7-0 give RAM address bits 7 down to 0.
// - Pointer-high bits 5-3 are reserved; nothing depends on them.
// - Three-bit selector picks the register seen at address 07.
// - Low two selector bits are shared storage with configuration bits 1-0.
// - Any configuration write clears selector bit 2.
// - Configuration bit 7 holds software reset until written back to zero.
// - Software reset leaves interface mode and configuration untouched.
// - Software reset touches only status, next-ID and diagnostic status.
// - Configuration bit 6 enables chained commands; zero keeps single-command mode.
// - Bit 5 low holds driver enable, and pulses outside backplane, inactive.
// - Transmit enable resets to zero.
// - Configuration bit 2 selects backplane signalling for the line pulses.
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module hrp_host_regs
(
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic                  ram_data_access,
    output hrp_pkg::hrp_addr_t         ram_addr,
    output logic                       ram_read_select,
    output logic                       pointer_auto_step,
    output hrp_pkg::hrp_sel_t          indirect_sel,
    output hrp_pkg::hrp_target_t       indirect_target,
    output logic                       soft_reset,
    output logic                       command_queue_enable,
    output logic                       line_drive_enable,
    output logic                       backplane_mode,
    input  wire logic                  tx_pulse_a,
    input  wire logic                  tx_pulse_b,
    input  wire logic                  tx_drive,
    output logic                       line_pulse_a_n,
    output logic                       line_pulse_b_n,
    output logic                       driver_enable_n
);
    import hrp_pkg::*;

    hrp_bus_state_e  state;
    hrp_bus_state_e  next_state;
    hrp_offset_t     dph_addr;
    logic            addr_phase;
    logic            wr_en;
    hrp_byte_t       wr_byte;
    logic            wr_ptr_high;
    logic            wr_ptr_low;
    logic            wr_sel;
    logic            wr_cfg;
    logic [5:0]      cfg;
    hrp_sel_t        next_sel;
    hrp_target_t     next_target;
    hrp_byte_t       rd_value;
    logic            ptr_step;

    // The transfer size is not decoded: every access moves the low byte.
    logic            size_unused;
    assign size_unused = ^hsize;

    // Bus side: writes finish with no wait, reads take one wait state so
    // that a read straight after a write returns the updated value.
    assign addr_phase = hsel && (htrans == HTRANS_NONSEQ) && hready;

    always_comb
    begin
        next_state = state;
        unique case (state)
            HRP_ST_RD_FETCH:
            begin
                next_state = HRP_ST_RD_GIVE;
            end
            HRP_ST_IDLE, HRP_ST_WRITE, HRP_ST_RD_GIVE:
            begin
                if (addr_phase)
                begin
                    next_state = hwrite ? HRP_ST_WRITE : HRP_ST_RD_FETCH;
                end
                else
                begin
                    next_state = HRP_ST_IDLE;
                end
            end
            default:
            begin
                next_state = HRP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state <= HRP_ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            dph_addr <= REG_PTR_HIGH;
        end
        else if (addr_phase && (state != HRP_ST_RD_FETCH))
        begin
            dph_addr <= haddr[11:0];
        end
    end

    assign hreadyout = (state != HRP_ST_RD_FETCH);
    assign hresp     = HRESP_OKAY;

    assign wr_en       = (state == HRP_ST_WRITE);
    assign wr_byte     = hwdata[7:0];
    assign wr_ptr_high = wr_en && (dph_addr == REG_PTR_HIGH);
    assign wr_ptr_low  = wr_en && (dph_addr == REG_PTR_LOW);
    assign wr_sel      = wr_en && (dph_addr == REG_SEL);
    assign wr_cfg      = wr_en && (dph_addr == REG_CONFIG);

    // Pointer-high control bits; reserved bits 5-3 are dropped on write.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ram_read_select   <= 1'b0;
            pointer_auto_step <= 1'b0;
        end
        else if (wr_ptr_high)
        begin
            ram_read_select   <= wr_byte[PH_READ_BIT];
            pointer_auto_step <= wr_byte[PH_STEP_BIT];
        end
    end

    assign ptr_step = ram_data_access && pointer_auto_step;

    hrp_ptr_counter u_ptr
    (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .load_upper (wr_ptr_high),
        .load_lower (wr_ptr_low),
        .upper_in   (wr_byte[PH_UPPER_MSB:0]),
        .lower_in   (wr_byte),
        .step       (ptr_step),
        .ptr        (ram_addr)
    );

    // One selector store serves both views; a configuration write loads
    // the two shared bits and forces the upper bit low.
    always_comb
    begin
        next_sel = indirect_sel;
        if (wr_cfg)
        begin
            next_sel = {1'b0, wr_byte[SEL_SHARED_MSB:0]};
        end
        else if (wr_sel)
        begin
            next_sel = wr_byte[2:0];
        end
    end

    always_comb
    begin
        next_target = TGT_NONE;
        unique case (next_sel)
            SEL_TENTATIVE_ID:
            begin
                next_target = TGT_TENTATIVE_ID;
            end
            SEL_NODE_ID:
            begin
                next_target = TGT_NODE_ID;
            end
            SEL_SETUP_1:
            begin
                next_target = TGT_SETUP_1;
            end
            SEL_NEXT_ID:
            begin
                next_target = TGT_NEXT_ID;
            end
            SEL_SETUP_2:
            begin
                next_target = TGT_SETUP_2;
            end
            default:
            begin
                next_target = TGT_NONE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            indirect_sel    <= SEL_RESET;
            indirect_target <= TGT_TENTATIVE_ID;
        end
        else
        begin
            indirect_sel    <= next_sel;
            indirect_target <= next_target;
        end
    end

    // Configuration bits 7-2; only a host write or the hardware reset clears them, so the
    // software reset bit cannot clear itself or its neighbours.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cfg <= CFG_RESET;
        end
        else if (wr_cfg)
        begin
            cfg <= wr_byte[7:CFG_KEEP_LSB];
        end
    end

    assign soft_reset           = cfg[CFG_RESET_BIT - CFG_KEEP_LSB];
    assign command_queue_enable = cfg[CFG_CHAIN_BIT - CFG_KEEP_LSB];
    assign line_drive_enable    = cfg[CFG_LINE_DRIVE_ENABLE_BIT - CFG_KEEP_LSB];
    assign backplane_mode       = cfg[CFG_BACKPLANE_BIT - CFG_KEEP_LSB];

    // Line outputs are gated by transmit enable; in backplane signalling
    // the two pulse lines are left to the transmitter.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            line_pulse_a_n  <= 1'b1;
            line_pulse_b_n  <= 1'b1;
            driver_enable_n <= 1'b1;
        end
        else
        begin
            line_pulse_a_n  <= !(tx_pulse_a && (line_drive_enable || backplane_mode));
            line_pulse_b_n  <= !(tx_pulse_b && (line_drive_enable || backplane_mode));
            driver_enable_n <= !(tx_drive && line_drive_enable);
        end
    end

    // Read multiplexer; reserved and unmapped bits read as zero.
    always_comb
    begin
        rd_value = RD_ZERO;
        unique case (dph_addr)
            REG_PTR_HIGH:
            begin
                rd_value = {ram_read_select, pointer_auto_step, 3'h0,
                            ram_addr[10:8]};
            end
            REG_PTR_LOW:
            begin
                rd_value = ram_addr[7:0];
            end
            REG_SEL:
            begin
                rd_value = {5'h00, indirect_sel};
            end
            REG_CONFIG:
            begin
                rd_value = {cfg, indirect_sel[SEL_SHARED_MSB:0]};
            end
            default:
            begin
                rd_value = RD_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (state == HRP_ST_RD_FETCH)
        begin
            hrdata <= {24'h00_0000, rd_value};
        end
    end

endmodule : hrp_host_regs

`default_nettype wire

// file: design/hrp_ptr_counter.sv
// Eleven-bit RAM address pointer with byte loads and a wrapping step.
`timescale 1ns/1ps
`default_nettype none

module hrp_ptr_counter
(
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    input  wire logic            load_upper,
    input  wire logic            load_lower,
    input  wire logic [2:0]      upper_in,
    input  wire hrp_pkg::hrp_byte_t lower_in,
    input  wire logic            step,
    output var  hrp_pkg::hrp_addr_t ptr
);
    import hrp_pkg::*;

    // A host load wins over a step that lands in the same cycle.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ptr <= PTR_RESET;
        end
        else if (load_upper || load_lower)
        begin
            ptr <= {load_upper ? upper_in : ptr[10:8],
                    load_lower ? lower_in : ptr[7:0]};
        end
        else if (step)
        begin
            ptr <= ptr + PTR_STEP;
        end
    end

endmodule : hrp_ptr_counter

`default_nettype wire

// file: verif/hrp_host_model.sv
// Host bus master model that issues single AHB-Lite word transfers.
`timescale 1ns/1ps
`default_nettype none
module hrp_host_model
(
    input  wire logic        clk_sys,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    import hrp_pkg::*;
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Called just after a rising edge; returns just after the data phase edge.
    task automatic xfer(input logic wr, input hrp_offset_t a, input hrp_byte_t wd,
                        output hrp_byte_t rd, output logic ok);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= wr;
        // The address phase stands until hready is seen high at a rising edge.
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 64);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        // The data phase ends, and read data is taken, at the next edge with hready high.
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 64);
        rd = hrdata[7:0];
        ok = n < 64;
    endtask : xfer
endmodule : hrp_host_model
`default_nettype wire

// file: verif/hrp_host_regs_assertions.sv
// Concurrent checks on the ports of the host register group.
`timescale 1ns/1ps
`default_nettype none
module hrp_host_regs_assertions
    import hrp_pkg::*;
(
    input wire logic                 clk_sys,
    input wire logic                 sys_rst,
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 ram_data_access,
    input wire hrp_pkg::hrp_addr_t   ram_addr,
    input wire logic                 pointer_auto_step,
    input wire hrp_pkg::hrp_sel_t    indirect_sel,
    input wire hrp_pkg::hrp_target_t indirect_target,
    input wire logic                 line_drive_enable,
    input wire logic                 backplane_mode,
    input wire logic                 tx_pulse_a,
    input wire logic                 tx_drive,
    input wire logic                 line_pulse_a_n,
    input wire logic                 driver_enable_n
);
    logic wr_ptr;
    // Marks the data phase of a host pointer write, which beats a step.
    always_ff @(posedge clk_sys)
    begin
        wr_ptr <= hsel && htrans == HTRANS_NONSEQ && hready && hwrite && haddr[11:3] == 9'h0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_rd;
        hsel && htrans == HTRANS_NONSEQ && hready && !hwrite;
    endsequence
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_wr_cfg;
        hsel && htrans == HTRANS_NONSEQ && hready && hwrite && haddr[11:0] == REG_CONFIG;
    endsequence
    a_step_adds_one: assert property (
        ram_data_access && pointer_auto_step && !wr_ptr
        |=> ram_addr == $past(ram_addr) + 11'h1) else $error("pointer did not step by one");
    a_step_holds: assert property (!(ram_data_access && pointer_auto_step) && !wr_ptr
        |=> $stable(ram_addr)) else $error("pointer moved without a step");
    a_read_wait: assert property (s_rd |=> s_rd_wait) else $error("read wait state wrong");
    a_cfg_clears_sel: assert property (s_wr_cfg |-> ##2 !indirect_sel[2])
        else $error("selector bit 2 not cleared");
    a_target_map: assert property (indirect_target == (indirect_sel > 3'h4 ? TGT_NONE
        : hrp_target_t'(5'h01 << indirect_sel))) else $error("indirect target wrong");
    a_line_drive_enable_blocks: assert property (!line_drive_enable |=> driver_enable_n)
        else $error("driver enabled while transmit off");
    a_drive_passes: assert property (line_drive_enable && tx_drive |=> !driver_enable_n)
        else $error("driver enable not passed");
    a_pulse_blocks: assert property (
        !line_drive_enable && !backplane_mode |=> line_pulse_a_n)
        else $error("pulse active while transmit off");
    a_plane_pulse: assert property (backplane_mode && tx_pulse_a |=> !line_pulse_a_n)
        else $error("backplane pulse not passed");
endmodule : hrp_host_regs_assertions
bind hrp_host_regs hrp_host_regs_assertions u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .ram_data_access(ram_data_access), .ram_addr(ram_addr),
    .pointer_auto_step(pointer_auto_step), .indirect_sel(indirect_sel),
    .indirect_target(indirect_target), .line_drive_enable(line_drive_enable),
    .backplane_mode(backplane_mode), .tx_pulse_a(tx_pulse_a), .tx_drive(tx_drive),
    .line_pulse_a_n(line_pulse_a_n), .driver_enable_n(driver_enable_n));
`default_nettype wire

// file: verif/tb_host_ram_pointer_config_regs.sv
// Self-checking bench for the host register group.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb_host_ram_pointer_config_regs;
    import hrp_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp, ok, ram_read_select, pointer_auto_step;
    logic        soft_reset, command_queue_enable, line_drive_enable, backplane_mode;
    logic        line_pulse_a_n, line_pulse_b_n, driver_enable_n;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        ram_data_access = 1'b0;
    logic        tx_pulse_a = 1'b0;
    logic        tx_pulse_b = 1'b0;
    logic        tx_drive = 1'b0;
    hrp_addr_t   ram_addr;
    hrp_sel_t    indirect_sel;
    hrp_target_t indirect_target;
    hrp_byte_t   rd;
    int          mismatches = 0;
    int          check_count = 0;
    hrp_target_t exp_tgt [8] = '{TGT_TENTATIVE_ID, TGT_NODE_ID, TGT_SETUP_1, TGT_NEXT_ID,
                                 TGT_SETUP_2, TGT_NONE, TGT_NONE, TGT_NONE};
    always #20 clk_sys = ~clk_sys;
    hrp_host_model host (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    hrp_host_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ram_data_access(ram_data_access), .ram_addr(ram_addr),
        .ram_read_select(ram_read_select), .pointer_auto_step(pointer_auto_step),
        .indirect_sel(indirect_sel), .indirect_target(indirect_target),
        .soft_reset(soft_reset), .command_queue_enable(command_queue_enable),
        .line_drive_enable(line_drive_enable), .backplane_mode(backplane_mode),
        .tx_pulse_a(tx_pulse_a), .tx_pulse_b(tx_pulse_b), .tx_drive(tx_drive),
        .line_pulse_a_n(line_pulse_a_n), .line_pulse_b_n(line_pulse_b_n),
        .driver_enable_n(driver_enable_n));
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task xfer(input logic wr, input hrp_offset_t a, input hrp_byte_t d);
        host.xfer(wr, a, d, rd, ok);
        if (!ok)
        begin
            mismatches++;
            print_verdict();
        end
    endtask : xfer
    task rd_chk(input hrp_offset_t a, input hrp_byte_t e);
        xfer(1'b0, a, 8'h00);
        `CHK(rd, e)
    endtask : rd_chk
    task step(input hrp_addr_t e);
        ram_data_access <= 1'b1;
        @(posedge clk_sys);
        ram_data_access <= 1'b0;
        @(negedge clk_sys);
        `CHK(ram_addr, e)
        @(posedge clk_sys);
    endtask : step
    task line(input logic pa, input logic de);
        tx_pulse_a <= 1'b1;
        tx_pulse_b <= 1'b1;
        tx_drive <= 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(line_pulse_a_n, pa)
        `CHK(line_pulse_b_n, pa)
        `CHK(driver_enable_n, de)
        @(posedge clk_sys);
        tx_pulse_a <= 1'b0;
        tx_pulse_b <= 1'b0;
        tx_drive <= 1'b0;
    endtask : line
    initial
    begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        `CHK(line_drive_enable, 1'b0)
        `CHK(indirect_target, TGT_TENTATIVE_ID)
        `CHK(indirect_sel, SEL_RESET)
        `CHK(pointer_auto_step, 1'b0)
        `CHK(hresp, HRESP_OKAY)
        @(posedge clk_sys);
        rd_chk(REG_CONFIG, 8'h00);
        rd_chk(12'h010, RD_ZERO);
        xfer(1'b1, REG_PTR_HIGH, 8'hff);
        rd_chk(REG_PTR_HIGH, 8'hc7);
        xfer(1'b1, REG_PTR_LOW, 8'hff);
        @(negedge clk_sys);
        `CHK(ram_addr, 11'h7ff)
        `CHK(ram_read_select, 1'b1)
        `CHK(pointer_auto_step, 1'b1)
        @(posedge clk_sys);
        step(11'h000);
        rd_chk(REG_PTR_HIGH, 8'hc0);
        xfer(1'b1, REG_PTR_LOW, 8'hff);
        step(11'h100);
        xfer(1'b1, REG_PTR_HIGH, 8'h05);
        step(11'h500);
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, REG_SEL, hrp_byte_t'(i));
            @(negedge clk_sys);
            `CHK(indirect_target, exp_tgt[i])
            @(posedge clk_sys);
            rd_chk(REG_SEL, hrp_byte_t'(i));
        end
        xfer(1'b1, REG_CONFIG, 8'h01);
        rd_chk(REG_SEL, 8'h01);
        xfer(1'b1, REG_SEL, 8'h06);
        rd_chk(REG_CONFIG, 8'h02);
        xfer(1'b1, REG_CONFIG, 8'hfd);
        @(negedge clk_sys);
        `CHK({soft_reset, command_queue_enable, backplane_mode}, 3'h7)
        @(posedge clk_sys);
        rd_chk(REG_CONFIG, 8'hfd);
        rd_chk(REG_PTR_HIGH, 8'h05);
        xfer(1'b1, REG_CONFIG, 8'h21);
        @(negedge clk_sys);
        `CHK({soft_reset, command_queue_enable}, 2'h0)
        @(posedge clk_sys);
        line(1'b0, 1'b0);
        xfer(1'b1, REG_CONFIG, 8'h04);
        line(1'b0, 1'b1);
        xfer(1'b1, REG_CONFIG, 8'h00);
        line(1'b1, 1'b1);
        print_verdict();
    end
endmodule : tb_host_ram_pointer_config_regs
`default_nettype wire
